// *** core/aif_filter.sv ***
// Two-channel analog input sliding mean filter with APB registers
//
// Implementation choice: the APB interface to the registers.
module aif_filter
  import aif_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int FDEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter side
  input wire logic [DATA_W-1:0] adc_ch0_data,
  input wire logic [DATA_W-1:0] adc_ch1_data,
  output logic [NCH-1:0] range_sel
);

  localparam int FW = DATA_W + 1;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    aif_fsel_t [NCH-1:0] sel;
    logic [NCH-1:0] rng;
    logic [NCH-1:0] pend;
    logic [NCH-1:0][DATA_W-1:0] cap;
    logic [NCH-1:0][DATA_W-1:0] res;
    logic [NCH-1:0][SUM_W-1:0] sum;
    logic [NCH-1:0][WIN_W-1:0] cnt;
    logic [NCH-1:0][WIN_W-1:0] ptr;
    aif_state_t state;
    logic ch;
    logic [SUM_W:0] rem;
    logic [SUM_W-1:0] quo;
    logic [BITN_W-1:0] bitn;
  } aif_filter_st_t;

  aif_filter_st_t st_ff, nxt_st;

  // Per-channel sample history
  logic [DATA_W-1:0] hist [NCH][MAX_WIN];

  logic tick;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [FW-1:0] f_in_data, f_out_data;
  logic apb_take, cfg_wr;
  logic [WIN_W-1:0] cur_win, cur_cnt, cur_ptr;
  logic [SUM_W-1:0] new_ext, old_ext;
  logic [SUM_W:0] divisor;
  logic [31:0] cfg_word, stat_word;

  // Outputs straight from the state register
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign range_sel = st_ff.rng;

  // Sample period timer
  aif_tick #(
    .PERIOD(SAMPLE_CYCLES)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  // Captured samples queue here so the engine can take its time per sample
  aif_fifo #(
    .W(FW),
    .DEPTH(FDEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // Channel 0 goes first; channel tag rides in the top bit
  assign f_in_valid = |st_ff.pend;
  assign f_in_data = st_ff.pend[0] ? {1'b0, st_ff.cap[0]} : {1'b1, st_ff.cap[1]};
  assign f_out_ready = (st_ff.state == ST_IDLE);

  // Views of the channel being processed
  assign cur_win = aif_win_len(st_ff.sel[st_ff.ch]);
  assign cur_cnt = st_ff.cnt[st_ff.ch];
  assign cur_ptr = st_ff.ptr[st_ff.ch];
  assign new_ext = {{(SUM_W-DATA_W){1'b0}}, st_ff.quo[DATA_W-1:0]};
  assign old_ext = {{(SUM_W-DATA_W){1'b0}}, hist[st_ff.ch][cur_ptr]};
  assign divisor = {{(SUM_W+1-WIN_W){1'b0}}, cur_cnt};

  // APB phases: answer one cycle into the access phase, act on the completing edge
  assign apb_take = psel && penable && !st_ff.pready;
  assign cfg_wr = psel && penable && st_ff.pready && pwrite && (paddr == ADDR_CFG);

  // Readable words built from the field layout
  always_comb begin
    cfg_word = '0;
    stat_word = '0;
    for (int c = 0; c < NCH; c++) begin
      cfg_word[CFG_SEL_LSB + c*CFG_CH_STRIDE +: 2] = st_ff.sel[c];
      cfg_word[CFG_RNG_BIT + c*CFG_CH_STRIDE] = st_ff.rng[c];
      stat_word[STAT_FULL_LSB + c] = (st_ff.cnt[c] == aif_win_len(st_ff.sel[c]));
    end
    stat_word[STAT_BUSY_BIT] = (st_ff.state != ST_IDLE);
  end

  // Next state of capture, averaging engine and register file
  always_comb begin
    logic [SUM_W:0] trial;
    aif_fsel_t new_sel;
    logic new_rng;
    trial = '0;
    new_sel = FSEL_NONE;
    new_rng = 1'b0;
    nxt_st = st_ff;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;

    // A pushed sample leaves the pending set; a new tick wins over the clear
    if (f_in_valid && f_in_ready) begin
      if (st_ff.pend[0]) nxt_st.pend[0] = 1'b0;
      else nxt_st.pend[1] = 1'b0;
    end
    if (tick) begin
      nxt_st.pend = '1;
      nxt_st.cap[0] = adc_ch0_data;
      nxt_st.cap[1] = adc_ch1_data;
    end

    // Averaging engine
    case (st_ff.state)
      ST_IDLE: begin
        if (f_out_valid) begin
          nxt_st.ch = f_out_data[DATA_W];
          nxt_st.quo = {{(SUM_W-DATA_W){1'b0}}, f_out_data[DATA_W-1:0]};
          nxt_st.state = ST_ACCUM;
        end
      end
      ST_ACCUM: begin
        if (cur_cnt == cur_win) begin
          // Full window: swap the oldest sample for the newest
          nxt_st.sum[st_ff.ch] = st_ff.sum[st_ff.ch] + new_ext - old_ext;
        end else begin
          // Still filling: grow the window, nothing stale enters the sum
          nxt_st.sum[st_ff.ch] = st_ff.sum[st_ff.ch] + new_ext;
          nxt_st.cnt[st_ff.ch] = cur_cnt + 1'b1;
        end
        nxt_st.ptr[st_ff.ch] = (cur_ptr + 1'b1 == cur_win) ? '0 : cur_ptr + 1'b1;
        nxt_st.quo = nxt_st.sum[st_ff.ch];
        nxt_st.rem = '0;
        nxt_st.bitn = BITN_W'(SUM_W);
        nxt_st.state = ST_DIV;
      end
      ST_DIV: begin
        // Restoring division, one quotient bit per cycle; slow but tiny,
        // and a sample arrives only every few hundred thousand cycles
        trial = {st_ff.rem[SUM_W-1:0], st_ff.quo[SUM_W-1]};
        if (trial >= divisor) begin
          nxt_st.rem = trial - divisor;
          nxt_st.quo = {st_ff.quo[SUM_W-2:0], 1'b1};
        end else begin
          nxt_st.rem = trial;
          nxt_st.quo = {st_ff.quo[SUM_W-2:0], 1'b0};
        end
        nxt_st.bitn = st_ff.bitn - 1'b1;
        if (st_ff.bitn == BITN_W'(1)) nxt_st.state = ST_STORE;
      end
      ST_STORE: begin
        nxt_st.res[st_ff.ch] = st_ff.quo[DATA_W-1:0];
        nxt_st.state = ST_IDLE;
      end
      default: begin
        nxt_st.state = ST_IDLE;
      end
    endcase

    // Register read and error answer, formed in the first access cycle and given in the second
    if (apb_take) begin
      nxt_st.pready = 1'b1;
      nxt_st.prdata = '0;
      if (!aif_addr_known(paddr)) begin
        nxt_st.pslverr = 1'b1;
      end else if (pwrite) begin
        nxt_st.pslverr = (paddr != ADDR_CFG);
      end else if (paddr == ADDR_RES0) begin
        nxt_st.prdata = {{(32-DATA_W){1'b0}}, st_ff.res[0]};
      end else if (paddr == ADDR_RES1) begin
        nxt_st.prdata = {{(32-DATA_W){1'b0}}, st_ff.res[1]};
      end else if (paddr == ADDR_CFG) begin
        nxt_st.prdata = cfg_word;
      end else begin
        nxt_st.prdata = stat_word;
      end
    end

    // Configuration write; a changed channel restarts its window
    if (cfg_wr) begin
      for (int c = 0; c < NCH; c++) begin
        new_sel = aif_fsel_t'(pwdata[CFG_SEL_LSB + c*CFG_CH_STRIDE +: 2]);
        new_rng = pwdata[CFG_RNG_BIT + c*CFG_CH_STRIDE];
        nxt_st.sel[c] = new_sel;
        nxt_st.rng[c] = new_rng;
        if (new_sel != st_ff.sel[c] || new_rng != st_ff.rng[c]) begin
          nxt_st.sum[c] = '0;
          nxt_st.cnt[c] = '0;
          nxt_st.ptr[c] = '0;
          // Drop a sample in flight so it cannot land in the fresh window
          // A sample already in store keeps its result; only unfinished work is dropped
          if ((st_ff.state == ST_ACCUM || st_ff.state == ST_DIV) && st_ff.ch == c[0]) begin
            nxt_st.state = ST_IDLE;
          end
        end
      end
    end
  end

  // State register; reset gives voltage range and the medium filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.state <= ST_IDLE;
      st_ff.sel <= '{default: RST_FSEL};
      st_ff.rng <= {NCH{RST_RNG}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // History write; the read of the slot above sees the old sample this cycle
  always_ff @(posedge pclk) begin
    if (st_ff.state == ST_ACCUM) hist[st_ff.ch][cur_ptr] <= st_ff.quo[DATA_W-1:0];
  end

  // Helper logic seen only by the checks below
  logic cfg_seen_ff, tick_seen_ff;
  logic [31:0] gap_ff;
  logic [47:0] mean_lo, mean_hi;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_seen_ff <= 1'b0;
      tick_seen_ff <= 1'b0;
      gap_ff <= '0;
    end else begin
      if (cfg_wr) cfg_seen_ff <= 1'b1;
      if (tick) tick_seen_ff <= 1'b1;
      gap_ff <= tick ? '0 : gap_ff + 1'b1;
    end
  end
  assign mean_lo = 48'(st_ff.quo) * 48'(cur_cnt);
  assign mean_hi = 48'(st_ff.quo + 1'b1) * 48'(cur_cnt);

  AST_RES0_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_take && !pwrite && paddr == ADDR_RES0) |=>
      (pready && !pslverr && prdata == {16'h0000, $past(st_ff.res[0])}))
    else $error("channel 0 result not returned");

  AST_RES1_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_take && !pwrite && paddr == ADDR_RES1) |=>
      (pready && !pslverr && prdata == {16'h0000, $past(st_ff.res[1])}))
    else $error("channel 1 result not returned");

  AST_RANGE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_wr |=> (range_sel[0] == $past(pwdata[CFG_RNG_BIT]) &&
                range_sel[1] == $past(pwdata[CFG_RNG_BIT + CFG_CH_STRIDE])))
    else $error("range selection not applied");

  AST_RANGE_DEFAULT: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_seen_ff |-> (range_sel == {NCH{RNG_VOLT}}))
    else $error("range not voltage before configuration");

  AST_SAMPLE_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && tick_seen_ff) |-> (gap_ff == 32'(SAMPLE_CYCLES - 1)))
    else $error("sample period wrong");

  AST_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> (st_ff.pend == 2'b11 && st_ff.cap[0] == $past(adc_ch0_data) &&
              st_ff.cap[1] == $past(adc_ch1_data)))
    else $error("sample not captured on tick");

  AST_MEAN: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff.state == ST_STORE) |->
      (mean_lo <= 48'(st_ff.sum[st_ff.ch]) && mean_hi > 48'(st_ff.sum[st_ff.ch]))
      ##1 (st_ff.res[$past(st_ff.ch)] == $past(st_ff.quo[DATA_W-1:0])))
    else $error("result is not the window mean");

  AST_WIN_CAP: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff.cnt[0] <= aif_win_len(st_ff.sel[0]) && st_ff.cnt[1] <= aif_win_len(st_ff.sel[1])))
    else $error("window longer than the filter time allows");

  AST_DEFAULT_FILTER: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_seen_ff |-> (st_ff.sel[0] == FSEL_MED && st_ff.sel[1] == FSEL_MED))
    else $error("default filter time not 1000 ms");

  AST_FILL: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff.state == ST_ACCUM && cur_cnt < cur_win && !cfg_wr) |=>
      (st_ff.state == ST_DIV && cur_cnt == $past(cur_cnt) + 1'b1))
    else $error("filling window did not grow by one");

endmodule : aif_filter

// *** core/aif_pkg.sv ***
// Constants, types and helpers shared by the analog input averaging filter
package aif_pkg;

  // Clock and sample timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_SAMPLE_NS = 2_000_000;
  localparam int T_SAMPLE_MS = 2;
  localparam int SAMPLE_CYC = T_SAMPLE_NS / CLK_PERIOD_NS;

  // Filter times in ms and the window lengths they give
  localparam int FT_NONE_MS = 2;
  localparam int FT_SMALL_MS = 100;
  localparam int FT_MED_MS = 1000;
  localparam int FT_LARGE_MS = 10000;
  localparam int WIN_NONE = FT_NONE_MS / T_SAMPLE_MS;
  localparam int WIN_SMALL = FT_SMALL_MS / T_SAMPLE_MS;
  localparam int WIN_MED = FT_MED_MS / T_SAMPLE_MS;
  localparam int WIN_LARGE = FT_LARGE_MS / T_SAMPLE_MS;
  localparam int MAX_WIN = WIN_LARGE;

  // Datapath widths
  localparam int DATA_W = 16;
  localparam int SUM_W = 32;
  localparam int WIN_W = 13;
  localparam int BITN_W = 6;
  localparam int ADDR_W = 14;
  localparam int NCH = 2;
  localparam int FIFO_DEPTH = 8;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_RES0 = 12'h320;
  localparam logic [11:0] IDX_RES1 = 12'h322;
  localparam logic [11:0] IDX_CFG = 12'h324;
  localparam logic [11:0] IDX_STAT = 12'h326;
  localparam logic [ADDR_W-1:0] ADDR_RES0 = {IDX_RES0, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RES1 = {IDX_RES1, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CFG = {IDX_CFG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STAT = {IDX_STAT, 2'b00};

  // Configuration field layout, one group of four bits per channel
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_RNG_BIT = 2;
  localparam int CFG_CH_STRIDE = 4;
  // Status field layout
  localparam int STAT_FULL_LSB = 0;
  localparam int STAT_BUSY_BIT = 2;

  // Filter time selection
  typedef enum logic [1:0] {
    FSEL_NONE = 2'h0,
    FSEL_SMALL = 2'h1,
    FSEL_MED = 2'h2,
    FSEL_LARGE = 2'h3
  } aif_fsel_t;

  // Measuring range: 0 = voltage 0..10V, 1 = current 4..20mA
  localparam logic RNG_VOLT = 1'b0;
  localparam logic RNG_CURR = 1'b1;
  localparam aif_fsel_t RST_FSEL = FSEL_MED;
  localparam logic RST_RNG = RNG_VOLT;

  // Engine states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ACCUM = 4'h2,
    ST_DIV = 4'h4,
    ST_STORE = 4'h8
  } aif_state_t;

  // Window length for a filter time selection
  function automatic logic [WIN_W-1:0] aif_win_len(input aif_fsel_t s);
    case (s)
      FSEL_NONE: aif_win_len = WIN_W'(WIN_NONE);
      FSEL_SMALL: aif_win_len = WIN_W'(WIN_SMALL);
      FSEL_MED: aif_win_len = WIN_W'(WIN_MED);
      default: aif_win_len = WIN_W'(WIN_LARGE);
    endcase
  endfunction : aif_win_len

  // True for an address that holds a register
  function automatic logic aif_addr_known(input logic [ADDR_W-1:0] a);
    aif_addr_known = (a == ADDR_RES0) || (a == ADDR_RES1) || (a == ADDR_CFG) ||
                     (a == ADDR_STAT);
  endfunction : aif_addr_known

endpackage : aif_pkg

// *** core/aif_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides
module aif_fifo
  import aif_pkg::*;
#(
  parameter int W = 17,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } aif_fifo_st_t;

  aif_fifo_st_t st_ff, nxt_st;
  logic [W-1:0] mem [DEPTH];
  logic full, empty, push, pop;

  // Extra pointer bit tells full from empty
  assign empty = (st_ff.wptr == st_ff.rptr);
  assign full = (st_ff.wptr[AW-1:0] == st_ff.rptr[AW-1:0]) && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;
  assign out_data = mem[st_ff.rptr[AW-1:0]];

  // Pointer update
  always_comb begin
    nxt_st = st_ff;
    if (push) nxt_st.wptr = st_ff.wptr + 1'b1;
    if (pop) nxt_st.rptr = st_ff.rptr + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  // Storage needs no reset; only written slots are ever read
  always_ff @(posedge pclk) begin
    if (push) mem[st_ff.wptr[AW-1:0]] <= in_data;
  end

  AST_FIFO_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    (AW+1)'(st_ff.wptr - st_ff.rptr) <= (AW+1)'(DEPTH))
    else $error("fifo level above depth");

endmodule : aif_fifo

// *** core/aif_tick.sv ***
// Free running sample period timer
module aif_tick #(
  parameter int PERIOD = 500000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // One-cycle pulse every PERIOD cycles
  output logic tick
);

  localparam int CW = $clog2(PERIOD);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } aif_tick_st_t;

  aif_tick_st_t st_ff, nxt_st;

  assign tick = st_ff.tick;

  // Count up through the period and pulse on wrap
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = (st_ff.cnt == CW'(PERIOD - 1));
    nxt_st.cnt = nxt_st.tick ? '0 : st_ff.cnt + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_ff <= '0;
    else st_ff <= nxt_st;
  end

endmodule : aif_tick

// *** dv/aif_adc_model.sv ***
// Behavioural converter that turns bench levels into codes for the filter
module aif_adc_model
  import aif_pkg::*;
#(
  parameter int SLOW = 0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Analog levels as codes, set by the bench
  input wire logic [DATA_W-1:0] level0,
  input wire logic [DATA_W-1:0] level1,
  // Converted codes to the filter
  output logic [DATA_W-1:0] adc_ch0_data,
  output logic [DATA_W-1:0] adc_ch1_data
);
  logic [DATA_W-1:0] s0_ff;
  logic [DATA_W-1:0] s1_ff;
  logic [DATA_W-1:0] d0_ff;
  logic [DATA_W-1:0] d1_ff;

  // Conversion pipeline; the slow build adds one stage of latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s0_ff <= 16'h0000;
      s1_ff <= 16'h0000;
      d0_ff <= 16'h0000;
      d1_ff <= 16'h0000;
    end else begin
      s0_ff <= level0;
      s1_ff <= level1;
      d0_ff <= s0_ff;
      d1_ff <= s1_ff;
    end
  end

  // Codes are held as levels, as a converter output register would be
  assign adc_ch0_data = (SLOW != 0) ? d0_ff : s0_ff;
  assign adc_ch1_data = (SLOW != 0) ? d1_ff : s1_ff;
endmodule : aif_adc_model

// *** dv/aif_filter_tb_top.sv ***
// Self-checking bench for the two-channel sliding mean filter
module aif_filter_tb_top import aif_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // Short sample period keeps the 500-sample window affordable in run time
  localparam int SC = 128;
  localparam int PH_SET = 115;
  localparam int PH_RD = 95;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [DATA_W-1:0] adc0;
  logic [DATA_W-1:0] adc1;
  logic [DATA_W-1:0] lv0;
  logic [DATA_W-1:0] lv1;
  logic [NCH-1:0] range_sel;
  int cyc_ff;
  int fails;
  int n_checks;

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Phase counter, restarted by every reset just like the sample timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_ff <= 0;
    end else begin
      cyc_ff <= cyc_ff + 1;
    end
  end

  aif_adc_model #(.SLOW(1)) u_adc (.pclk(pclk), .presetn(presetn), .level0(lv0),
    .level1(lv1), .adc_ch0_data(adc0), .adc_ch1_data(adc1));

  aif_filter #(.SAMPLE_CYCLES(SC), .FDEPTH(FIFO_DEPTH)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_ch0_data(adc0),
    .adc_ch1_data(adc1), .range_sel(range_sel));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Settles one step past the edge so the phase counter is read safely
  task automatic wait_phase(input int p);
    do begin
      @(posedge pclk);
      #1;
    end while (cyc_ff % SC != p);
  endtask : wait_phase

  // One APB transfer; request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    check({31'h0, pready}, 32'h0000_0001);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    check({31'h0, err}, {31'h0, e});
  endtask : wr

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic e);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, d);
    check({31'h0, err}, {31'h0, e});
  endtask : rdc

  // Config writes land after both stores and before the next tick
  task automatic cfg(input logic [31:0] d);
    wait_phase(PH_RD);
    wr(ADDR_CFG, d, 1'b0);
  endtask : cfg

  // Levels change far from the tick, so each period captures exactly one pair
  task automatic feed(input int v0, input int v1, input int n);
    repeat (n) begin
      wait_phase(PH_SET);
      @(posedge pclk);
      lv0 <= DATA_W'(v0);
      lv1 <= DATA_W'(v1);
      wait_phase(PH_RD);
    end
  endtask : feed

  task automatic res(input int e0, input int e1, input logic [31:0] st);
    rdc(ADDR_RES0, 32'(e0), 1'b0);
    rdc(ADDR_RES1, 32'(e1), 1'b0);
    rdc(ADDR_STAT, st, 1'b0);
  endtask : res

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
  endtask : do_reset

  // Watchdog, sized well above the roughly 72k cycles the sequence needs
  initial begin
    repeat (90000) @(posedge pclk);
    fails++;
    $display("Error t=%0t got=%h exp=%h", $time, 32'h0000_0000, 32'h0000_0001);
    tally_and_finish();
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h0000_0000;
    lv0 = 16'h0000;
    lv1 = 16'h0000;
    rd = 32'h0000_0000;
    err = 1'b0;
    fails = 0;
    n_checks = 0;
    do_reset();
    // Defaults, per-channel range and register access
    check({30'h0, range_sel}, 32'h0000_0000);
    rdc(ADDR_CFG, 32'h0000_0022, 1'b0);
    wr(ADDR_CFG, 32'h0000_0026, 1'b0);
    @(posedge pclk);
    #1;
    check({30'h0, range_sel}, 32'h0000_0001);
    wr(ADDR_CFG, 32'h0000_0062, 1'b0);
    @(posedge pclk);
    #1;
    check({30'h0, range_sel}, 32'h0000_0002);
    wr(ADDR_RES0, 32'h0000_FFFF, 1'b1);
    wr(ADDR_RES1, 32'h0000_FFFF, 1'b1);
    rdc(ADDR_RES0 + 14'h0001, 32'h0000_0000, 1'b1);
    rdc(ADDR_RES0 + 14'h0004, 32'h0000_0000, 1'b1);
    rdc(ADDR_CFG, 32'h0000_0062, 1'b0);
    // No filtering: every result is the latest sample, boundary codes included
    cfg(32'h0000_0000);
    feed(16'h1234, 16'hABCD, 1);
    res(16'h1234, 16'hABCD, 32'h0000_0003);
    feed(16'hFFFF, 16'h0001, 1);
    res(16'hFFFF, 16'h0001, 32'h0000_0003);
    // Small window: partial means, filling, then the oldest sample drops out
    cfg(32'h0000_0011);
    feed(100, 300, 1);
    res(100, 300, 32'h0000_0000);
    feed(200, 500, 1);
    res(150, 400, 32'h0000_0000);
    feed(1000, 2000, 47);
    res((300 + 47 * 1000) / 49, (800 + 47 * 2000) / 49, 32'h0000_0000);
    feed(1000, 2000, 1);
    res(48300 / 50, 96800 / 50, 32'h0000_0003);
    feed(1000, 2000, 1);
    res(49200 / 50, 98500 / 50, 32'h0000_0003);
    // Large window only starts filling in this run
    cfg(32'h0000_0033);
    feed(10, 20, 1);
    feed(20, 40, 1);
    feed(31, 61, 1);
    res(61 / 3, 121 / 3, 32'h0000_0000);
    // Engine busy while the next sample is being divided
    wait_phase(10);
    rdc(ADDR_STAT, 32'h0000_0004, 1'b0);
    // Second reset mid-run brings back voltage range and the 500-sample window
    cfg(32'h0000_0066);
    @(posedge pclk);
    do_reset();
    check({30'h0, range_sel}, 32'h0000_0000);
    feed(7, 9, 499);
    res(7, 9, 32'h0000_0000);
    feed(7, 9, 1);
    res(7, 9, 32'h0000_0003);
    feed(507, 509, 1);
    res(4000 / 500, 5000 / 500, 32'h0000_0003);
    tally_and_finish();
  end
endmodule : aif_filter_tb_top
